/* src/srpc_pkg.sv */
// shared constants and carrier types for the sync reference pin control block
package srpc_pkg;
    // control port subaddresses
    localparam logic [7:0] SRPC_ADDR_PIN_CFG = 8'h6B; // sync pin configuration
    localparam logic [7:0] SRPC_ADDR_HTRIG_LO = 8'h6C; // trigger phase low byte
    localparam logic [7:0] SRPC_ADDR_TRIG_HI = 8'h6D; // htrig msbs and vtrig
    // reset values
    localparam logic [7:0] SRPC_PIN_CFG_RST = 8'h00;
    localparam logic [10:0] SRPC_HTRIG_RST = 11'h000;
    localparam logic [4:0] SRPC_VTRIG_RST = 5'h00;
    // field positions inside the pin configuration byte
    localparam int SRPC_B_TYPE_HI = 7;
    localparam int SRPC_B_TYPE_LO = 6;
    localparam int SRPC_B_HSRC = 5;
    localparam int SRPC_B_A_OE = 4;
    localparam int SRPC_B_A_POL = 3;
    localparam int SRPC_B_BLANK = 2;
    localparam int SRPC_B_B_OE = 1;
    localparam int SRPC_B_B_POL = 0;
    // port a signal types
    localparam logic [1:0] SRPC_TYPE_VS = 2'h0;
    localparam logic [1:0] SRPC_TYPE_FS = 2'h1;
    localparam logic [1:0] SRPC_TYPE_FIELD_SEQUENCE_MARKER = 2'h2;
    // timing counts, in pixel clocks, half lines and fields
    localparam logic [10:0] SRPC_LINE_CLKS = 11'h6C0; // 1728 clocks per line
    localparam logic [10:0] SRPC_HALF_CLKS = 11'h360; // half a line
    localparam logic [10:0] SRPC_FIELD_HALVES = 11'h271; // 625 half lines per field
    localparam logic [10:0] SRPC_VPULSE_HALVES = 11'h006; // width of vertical pulse
    localparam logic [3:0] SRPC_SEQ_NTSC = 4'h4;
    localparam logic [3:0] SRPC_SEQ_PAL = 4'h8;
    localparam logic [3:0] SRPC_SEQ_SEQUENTIAL_COLOUR_SEL = 4'hC;

    // register write port carrier
    typedef struct packed {
        logic we; // one-cycle write strobe
        logic [7:0] addr; // subaddress
        logic [7:0] wdata; // byte written
    } srpc_wr_t;

    // whole state of the block
    typedef struct packed {
        logic [7:0] cfg;
        logic [10:0] htrig;
        logic [4:0] vtrig;
        logic [7:0] rdata;
        logic a_s1, a_s2, a_s3;
        logic b_s1, b_s2, b_s3;
        logic [10:0] hcnt;
        logic [10:0] vhalf;
        logic [3:0] seq;
        logic a_out;
        logic b_out;
        logic blank;
    } srpc_state_t;
endpackage

/* src/srpc_top.sv */
// sync reference pin control: pin config register, timing counters, pin drivers
// How it works
// - config byte holds type, source, direction, polarity
// - type 00 vertical pulse, 01 frame marker
// - type 10 pulses every 4/8/12 fields
// - source 0: port a or embedded sync
// - source 1: horizontal sync from port b, or none with embedded sync
// - port a direction bit: 0 in, 1 out
// - port a polarity sets drive level, sample edge
// - blanking 0: horizontal reference pulse on port b
// - blanking 0: port b input used only for horizontal sync
// - blanking 1: pulse suppressed outside active lines
// - blanking 1 input: internal blanking plus sync with pin sync method
// - port b direction bit: 0 in, 1 out
// - port b polarity sets drive level, sample edge
// - horizontal trigger edge loads 11-bit phase
// - vertical trigger edge loads half-line phase
`timescale 1ns/1ns
module srpc_top #(
    parameter int LINE_W = 9 // width of first and last active line numbers
) (
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    input wire srpc_pkg::srpc_wr_t REG_WR_IN,
    output logic [7:0] REG_RDATA_OUT,
    input wire logic SYNC_METHOD_SEL_IN,
    input wire logic ALTERNATING_PHASE_SEL_IN,
    input wire logic SEQUENTIAL_COLOUR_SEL_IN,
    input wire logic EMB_FRAME_SYNC_IN,
    input wire logic [10:0] PORT_B_PULSE_START_IN,
    input wire logic [10:0] PORT_B_PULSE_END_IN,
    input wire logic [LINE_W-1:0] FIRST_ACTIVE_LINE_IN,
    input wire logic [LINE_W-1:0] LAST_ACTIVE_LINE_IN,
    input wire logic SYNC_PORT_A_IN,
    output logic SYNC_PORT_A_OUT,
    output logic SYNC_PORT_A_OE_OUT,
    input wire logic SYNC_PORT_B_IN,
    output logic SYNC_PORT_B_OUT,
    output logic SYNC_PORT_B_OE_OUT,
    output logic BLANK_OUT,
    output logic [10:0] HCOUNT_OUT,
    output logic [10:0] VHALF_OUT
);
    import srpc_pkg::*;

    logic rst_s1_q, rst_n_q; // released reset, two stages
    srpc_state_t s_q, s_d; // all registered state
    logic pol_a, pol_b, oe_a, oe_b, hsrc; // decoded config fields
    logic [1:0] typ; // port a signal type
    logic a_edge, b_edge; // active edges of the synced pins
    logic h_evt, v_evt; // timing triggers
    logic [10:0] fhalf; // half line inside the current field
    logic [10:0] fline; // line inside the current field
    logic in_vs, win, active, fstart; // timing windows
    logic [3:0] seq_len; // field sequence length

    // reset release through two flops; assertion is immediate
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // field decode of the configuration byte
    assign typ = {s_q.cfg[SRPC_B_TYPE_HI], s_q.cfg[SRPC_B_TYPE_LO]};
    assign hsrc = s_q.cfg[SRPC_B_HSRC];
    assign oe_a = s_q.cfg[SRPC_B_A_OE];
    assign pol_a = s_q.cfg[SRPC_B_A_POL];
    assign oe_b = s_q.cfg[SRPC_B_B_OE];
    assign pol_b = s_q.cfg[SRPC_B_B_POL];

    // edge detect on the second and third flops; polarity flips which edge counts
    assign a_edge = (s_q.a_s2 ^ pol_a) & ~(s_q.a_s3 ^ pol_a);
    assign b_edge = (s_q.b_s2 ^ pol_b) & ~(s_q.b_s3 ^ pol_b);

    // horizontal trigger source; a pin driven by us never triggers us
    always_comb begin
        if (SYNC_METHOD_SEL_IN) begin
            h_evt = ~hsrc & EMB_FRAME_SYNC_IN;
        end else if (hsrc) begin
            h_evt = b_edge & ~oe_b;
        end else begin
            h_evt = a_edge & ~oe_a;
        end
    end
    assign v_evt = a_edge & ~oe_a;

    // position in field; vertical blanking judged per field
    assign fhalf = (s_q.vhalf < SRPC_FIELD_HALVES) ? s_q.vhalf : s_q.vhalf - SRPC_FIELD_HALVES;
    assign fline = {1'b0, fhalf[10:1]};
    assign in_vs = fhalf < SRPC_VPULSE_HALVES;
    assign win = (s_q.hcnt >= PORT_B_PULSE_START_IN) && (s_q.hcnt < PORT_B_PULSE_END_IN);
    assign active = (fline >= 11'(FIRST_ACTIVE_LINE_IN)) && (fline <= 11'(LAST_ACTIVE_LINE_IN));
    assign fstart = (s_q.vhalf == '0) || (s_q.vhalf == SRPC_FIELD_HALVES);
    always_comb begin
        if (SEQUENTIAL_COLOUR_SEL_IN) begin
            seq_len = SRPC_SEQ_SEQUENTIAL_COLOUR_SEL;
        end else if (ALTERNATING_PHASE_SEL_IN) begin
            seq_len = SRPC_SEQ_PAL;
        end else begin
            seq_len = SRPC_SEQ_NTSC;
        end
    end

    // next state of everything
    always_comb begin
        s_d = s_q;
        // register writes; unmapped subaddresses are ignored
        if (REG_WR_IN.we) begin
            case (REG_WR_IN.addr)
                SRPC_ADDR_PIN_CFG: s_d.cfg = REG_WR_IN.wdata;
                SRPC_ADDR_HTRIG_LO: s_d.htrig[7:0] = REG_WR_IN.wdata;
                SRPC_ADDR_TRIG_HI: begin
                    s_d.htrig[10:8] = REG_WR_IN.wdata[7:5];
                    s_d.vtrig = REG_WR_IN.wdata[4:0];
                end
                default: ;
            endcase
        end
        // read data follows the address every cycle, zero when unmapped
        case (REG_WR_IN.addr)
            SRPC_ADDR_PIN_CFG: s_d.rdata = s_q.cfg;
            SRPC_ADDR_HTRIG_LO: s_d.rdata = s_q.htrig[7:0];
            SRPC_ADDR_TRIG_HI: s_d.rdata = {s_q.htrig[10:8], s_q.vtrig};
            default: s_d.rdata = 8'h00;
        endcase
        // pin synchronisers; first stage feeds the second only
        s_d.a_s1 = SYNC_PORT_A_IN;
        s_d.a_s2 = s_q.a_s1;
        s_d.a_s3 = s_q.a_s2;
        s_d.b_s1 = SYNC_PORT_B_IN;
        s_d.b_s2 = s_q.b_s1;
        s_d.b_s3 = s_q.b_s2;
        // pixel counter; a trigger loads the phase so larger codes mean less delay
        if (h_evt) begin
            s_d.hcnt = s_q.htrig;
        end else if (s_q.hcnt >= SRPC_LINE_CLKS - 11'h001) begin
            s_d.hcnt = '0;
        end else begin
            s_d.hcnt = s_q.hcnt + 11'h001;
        end
        // half-line counter, advanced twice a line
        if (v_evt) begin
            s_d.vhalf = {6'h00, s_q.vtrig};
        end else if (!h_evt && (s_q.hcnt == SRPC_LINE_CLKS - 11'h001
                || s_q.hcnt == SRPC_HALF_CLKS - 11'h001)) begin
            if (s_q.vhalf >= SRPC_FIELD_HALVES + SRPC_FIELD_HALVES - 11'h001) begin
                s_d.vhalf = '0;
            end else begin
                s_d.vhalf = s_q.vhalf + 11'h001;
            end
        end
        // field sequence counter steps at the start of each field
        if (fstart && s_d.vhalf != s_q.vhalf) begin
            s_d.seq = (s_q.seq + 4'h1 >= seq_len) ? 4'h0 : s_q.seq + 4'h1;
        end
        // port a output, then polarity; code 11 idles at the inactive level
        case (typ)
            SRPC_TYPE_VS: s_d.a_out = in_vs ^ pol_a;
            SRPC_TYPE_FS: s_d.a_out = (s_q.vhalf < SRPC_FIELD_HALVES) ^ pol_a;
            SRPC_TYPE_FIELD_SEQUENCE_MARKER: s_d.a_out = (in_vs && s_q.seq == 4'h0) ^ pol_a;
            default: s_d.a_out = pol_a;
        endcase
        // port b output: reference pulse, or composite blanking without vblank
        if (s_q.cfg[SRPC_B_BLANK]) begin
            s_d.b_out = (win && active) ^ pol_b;
        end else begin
            s_d.b_out = win ^ pol_b;
        end
        // incoming blanking, only in input mode with pin sync method
        s_d.blank = s_q.cfg[SRPC_B_BLANK] & ~oe_b & ~SYNC_METHOD_SEL_IN
            & (s_q.b_s2 ^ pol_b);
    end

    // single state register
    always_ff @(posedge MCLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_q <= '0;
            s_q.cfg <= SRPC_PIN_CFG_RST;
            s_q.htrig <= SRPC_HTRIG_RST;
            s_q.vtrig <= SRPC_VTRIG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // pin enables follow the direction bits
    assign SYNC_PORT_A_OE_OUT = oe_a;
    assign SYNC_PORT_B_OE_OUT = oe_b;
    assign SYNC_PORT_A_OUT = s_q.a_out;
    assign SYNC_PORT_B_OUT = s_q.b_out;
    assign BLANK_OUT = s_q.blank;
    assign REG_RDATA_OUT = s_q.rdata;
    assign HCOUNT_OUT = s_q.hcnt;
    assign VHALF_OUT = s_q.vhalf;

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!rst_n_q);

    cfg_write_a: assert property (REG_WR_IN.we && REG_WR_IN.addr == SRPC_ADDR_PIN_CFG
        |=> s_q.cfg == $past(REG_WR_IN.wdata)) else $error("config byte not stored");
    a_dir_a: assert property (REG_WR_IN.we && REG_WR_IN.addr == SRPC_ADDR_PIN_CFG
        |=> SYNC_PORT_A_OE_OUT == $past(REG_WR_IN.wdata[4])) else $error("port a direction");
    b_dir_a: assert property (REG_WR_IN.we && REG_WR_IN.addr == SRPC_ADDR_PIN_CFG
        |=> SYNC_PORT_B_OE_OUT == $past(REG_WR_IN.wdata[1])) else $error("port b direction");
    type_idle_a: assert property (typ == 2'h3 |=> SYNC_PORT_A_OUT == $past(pol_a))
        else $error("port a active with type 11");
    vs_level_a: assert property (typ == SRPC_TYPE_VS && in_vs
        |=> SYNC_PORT_A_OUT == !$past(pol_a)) else $error("vertical pulse level");
    h_load_a: assert property (h_evt |=> HCOUNT_OUT == $past(s_q.htrig))
        else $error("horizontal phase not loaded");
    v_load_a: assert property (v_evt |=> VHALF_OUT == {6'h00, $past(s_q.vtrig)})
        else $error("vertical phase not loaded");
    horizontal_reference_pulse_win_a: assert property (!s_q.cfg[SRPC_B_BLANK] && win
        |=> SYNC_PORT_B_OUT == !$past(pol_b)) else $error("reference pulse missing");
    cbn_vbl_a: assert property (s_q.cfg[SRPC_B_BLANK] && !active
        |=> SYNC_PORT_B_OUT == $past(pol_b)) else $error("blanking pulse in vblank");
    b_in_only_a: assert property (SYNC_PORT_B_OE_OUT && !SYNC_METHOD_SEL_IN && hsrc
        |-> !h_evt) else $error("driven port b triggered timing");
    wrap_a: assert property (HCOUNT_OUT == SRPC_LINE_CLKS - 11'h001 && !h_evt
        |=> HCOUNT_OUT == 11'h000) else $error("line counter did not wrap");

    horizontal_reference_pulse_c: cover property (!s_q.cfg[SRPC_B_BLANK] && oe_b ##1 $rose(SYNC_PORT_B_OUT));
    hsync_b_c: cover property (hsrc && !SYNC_METHOD_SEL_IN && h_evt);
    field_sequence_marker_c: cover property (typ == SRPC_TYPE_FIELD_SEQUENCE_MARKER && SYNC_PORT_A_OUT != pol_a);
    blank_c: cover property ($rose(BLANK_OUT));
endmodule

/* verif/srpc_sync_src.sv */
// external sync source model facing one two-way sync pin
`timescale 1ns/1ns
module srpc_sync_src (
    input wire logic clk_in,
    input wire logic act_in,
    input wire logic pol_in,
    input wire logic dev_oe_in,
    input wire logic dev_val_in,
    output logic wire_out
);
    logic level_q = 1'b0; // level the source puts on the pin
    // edges leave just after the clock edge, on the side the polarity asks
    always_ff @(posedge clk_in) begin
        level_q <= act_in ^ pol_in;
    end
    // source lets go while the device drives, so the wire shows the device
    always_comb begin
        wire_out = dev_oe_in ? dev_val_in : level_q;
    end
endmodule

/* verif/srpc_tb.sv */
// self-checking bench for the sync reference pin control block
`timescale 1ns/1ns
module srpc_tb;
    import srpc_pkg::*;
    logic clk = 1'b0; // pixel clock
    logic rst_n = 1'b0; // reset, active low
    srpc_wr_t wr = '0; // register port
    logic sym = 1'b0, alternating_phase_sel = 1'b0, sec = 1'b0, emb = 1'b0; // loose inputs
    logic [10:0] bs = 11'h000, be = 11'h000; // port b window
    logic [8:0] first_active_line = 9'h000, last_active_line = 9'h1FF; // active line span
    logic a_act = 1'b0, b_act = 1'b0; // far side pulse commands
    logic [7:0] cfg = 8'h00; // copy of the pin config byte
    logic [7:0] rd;
    logic a_o, a_oe, b_o, b_oe, a_w, b_w, blank;
    logic [10:0] hc, vh, ht = 11'h000;
    logic [4:0] vt = 5'h00;
    int n_mismatch = 0, n_tests = 0, cyc = 0;

    srpc_top u_srpc_top (.MCLK_IN(clk), .RESET_N_IN(rst_n), .REG_WR_IN(wr), .REG_RDATA_OUT(rd),
        .SYNC_METHOD_SEL_IN(sym), .ALTERNATING_PHASE_SEL_IN(alternating_phase_sel),
        .SEQUENTIAL_COLOUR_SEL_IN(sec), .EMB_FRAME_SYNC_IN(emb), .PORT_B_PULSE_START_IN(bs),
        .PORT_B_PULSE_END_IN(be), .FIRST_ACTIVE_LINE_IN(first_active_line), .LAST_ACTIVE_LINE_IN(last_active_line),
        .SYNC_PORT_A_IN(a_w), .SYNC_PORT_A_OUT(a_o), .SYNC_PORT_A_OE_OUT(a_oe),
        .SYNC_PORT_B_IN(b_w), .SYNC_PORT_B_OUT(b_o), .SYNC_PORT_B_OE_OUT(b_oe),
        .BLANK_OUT(blank), .HCOUNT_OUT(hc), .VHALF_OUT(vh));
    srpc_sync_src u_srpc_sync_src_a (.clk_in(clk), .act_in(a_act), .pol_in(cfg[SRPC_B_A_POL]),
        .dev_oe_in(a_oe), .dev_val_in(a_o), .wire_out(a_w));
    srpc_sync_src u_srpc_sync_src_b (.clk_in(clk), .act_in(b_act), .pol_in(cfg[SRPC_B_B_POL]),
        .dev_oe_in(b_oe), .dev_val_in(b_o), .wire_out(b_w));

    always #5 clk = ~clk;

    // a hang is cut short well past the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic results();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // fields between sequence marks, picked by the colour system selects
    function automatic int seqlen(input logic pal_sel, input logic sec_sel);
        return sec_sel ? 12 : pal_sel ? 8 : 4;
    endfunction

    // one write strobe; the copy is updated by nba so the models see it cleanly
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= '{we: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        wr.we <= 1'b0;
        if (a == SRPC_ADDR_PIN_CFG) cfg <= d;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        wr.addr <= a;
        repeat (2) @(posedge clk);
        #1;
        check("readback", {3'h0, rd}, {3'h0, e});
    endtask

    // new random trigger phases, horizontal kept inside one line
    task automatic setrig();
        ht = 11'($urandom % 1728);
        vt = 5'($urandom);
        wreg(SRPC_ADDR_HTRIG_LO, ht[7:0]);
        wreg(SRPC_ADDR_TRIG_HI, {ht[10:8], vt});
    endtask

    // pulse source 0 a, 1 b, 2 embedded; then expect a load or a free run
    task automatic trig(input int src, input bit hit, input bit vchk);
        logic [10:0] h0;
        bit found = 0;
        @(posedge clk);
        #1;
        h0 = hc;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            a_act <= (src == 0) && (i < 6);
            b_act <= (src == 1) && (i < 6);
            emb <= (src == 2) && (i == 0);
            #1;
            if (hc === ht && (!vchk || vh === {6'h00, vt})) found = 1;
        end
        if (hit) begin
            check("trigger", 11'(found), 11'h001);
        end else begin
            check("free run", hc, 11'((int'(h0) + 12) % int'(SRPC_LINE_CLKS)));
        end
    endtask

    initial begin
        logic [7:0] d, a;
        logic [10:0] hp;
        logic [1:0] ty;
        bit p, en, wb;
        int nact;
        void'($urandom(42568));
        alternating_phase_sel <= 1'($urandom);
        repeat (5) @(posedge clk);
        #1;
        check("reset pins", {6'h00, a_o, a_oe, b_o, b_oe, blank}, 11'h000);
        check("reset counts", hc | vh, 11'h000);
        @(posedge clk) rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rreg(SRPC_ADDR_PIN_CFG, SRPC_PIN_CFG_RST);
        rreg(SRPC_ADDR_TRIG_HI, 8'h00);
        // random bytes everywhere, an unmapped place among them
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            a = (i % 4 == 3) ? 8'h6A : 8'h6B + 8'(i % 4);
            wreg(a, d);
            rreg(a, (a == 8'h6A) ? 8'h00 : d);
            if (a == SRPC_ADDR_PIN_CFG) begin
                check("oe", {9'h0, a_oe, b_oe}, {9'h0, d[4], d[1]});
            end
        end
        for (int k = 0; k < 2; k++) begin
            p = k[0];
            wreg(SRPC_ADDR_PIN_CFG, {2'b00, 1'b0, 1'b0, p, 1'b0, 1'b0, p});
            setrig();
            trig(0, 1, 1);
            wreg(SRPC_ADDR_PIN_CFG, {2'b00, 1'b1, 1'b0, p, 1'b0, 1'b0, p});
            setrig();
            trig(1, 1, 0);
            @(posedge clk) sym <= 1'b1;
            trig(1, 0, 0);
            wreg(SRPC_ADDR_PIN_CFG, {2'b00, 1'b0, 1'b0, p, 1'b0, 1'b0, p});
            trig(2, 1, 0);
            @(posedge clk) sym <= 1'b0;
            trig(1, 0, 0);
            // port a type codes, near the field start and further in
            for (int r = 0; r < 4; r++) begin
                ht[10:8] = 3'h0;
                vt = (r == 1 || r == 2) ? 5'h14 : 5'h00;
                ty = (r == 2) ? 2'b01 : (r == 3) ? 2'b11 : 2'b00;
                wreg(SRPC_ADDR_TRIG_HI, {3'h0, vt});
                wreg(SRPC_ADDR_PIN_CFG, {2'b00, 1'b0, 1'b0, p, 1'b0, 1'b0, p});
                trig(0, 1, 1);
                wreg(SRPC_ADDR_PIN_CFG, {ty, 1'b0, 1'b1, p, 1'b0, 1'b0, p});
                repeat (3) @(posedge clk);
                #1;
                check("port a", 11'(a_o), 11'(p ^ (r == 0 || r == 2)));
            end
            // field sequence: each load of 1 then 0 crosses one field start,
            // so over one full sequence the mark shows exactly once
            @(posedge clk) sec <= k[0];
            wreg(SRPC_ADDR_PIN_CFG, {2'b10, 1'b0, 1'b0, p, 1'b0, 1'b0, p});
            nact = 0;
            for (int f = 0; f < seqlen(alternating_phase_sel, sec); f++) begin
                for (int v = 1; v >= 0; v--) begin
                    vt = 5'(v);
                    wreg(SRPC_ADDR_TRIG_HI, {3'h0, vt});
                    trig(0, 1, 1);
                end
                nact += int'(a_o !== p);
            end
            check("field seq", 11'(nact), 11'h001);
            // port b drive over a whole line, reference and blanking modes
            for (int m = 0; m < 3; m++) begin
                @(posedge clk);
                bs <= 11'($urandom % 1300);
                be <= 11'(1300 + $urandom % 400);
                first_active_line <= (m == 1) ? 9'h000 : 9'h190;
                last_active_line <= (m == 1) ? 9'h1FF : 9'h1F4;
                en = (m != 2);
                wreg(SRPC_ADDR_PIN_CFG, {2'b00, 1'b0, 1'b0, p, 1'(m != 0), 1'b1, p});
                repeat (2) @(posedge clk);
                #1;
                hp = hc;
                for (int i = 0; i < 1800; i++) begin
                    @(posedge clk);
                    #1;
                    wb = en && hp >= bs && hp < be;
                    check("port b", 11'(b_o), 11'(p ^ wb));
                    hp = hc;
                end
            end
            // port b as input feeds blanking only in blanking mode
            for (int m = 0; m < 2; m++) begin
                wreg(SRPC_ADDR_PIN_CFG, {2'b00, 1'b0, 1'b0, p, m[0], 1'b0, p});
                @(posedge clk) b_act <= 1'b1;
                repeat (6) @(posedge clk);
                #1;
                check("blank on", 11'(blank), 11'(m));
                @(posedge clk) b_act <= 1'b0;
                repeat (6) @(posedge clk);
                #1;
                check("blank off", 11'(blank), 11'h000);
            end
        end
        results();
    end
endmodule
